// *** rtl/sarrd_params.svh ***
// timing counts and field constants for the converter readout sequencer
`ifndef SARRD_PARAMS_SVH
`define SARRD_PARAMS_SVH
`define SARRD_CLK_PERIOD_NS 10
`define SARRD_CONV_TIME_NS 4700
`define SARRD_CONV_CYCLES (`SARRD_CONV_TIME_NS / `SARRD_CLK_PERIOD_NS)
`define SARRD_WAKE_TIME_MS 10
`define SARRD_WAKE_CYCLES (`SARRD_WAKE_TIME_MS * 1000000 / `SARRD_CLK_PERIOD_NS)
`define SARRD_RESULT_BITS 16
`define SARRD_READ_DELAY_CYCLES 1
`endif

// *** rtl/sarrd_pkg.sv ***
// types shared by both ends of the converter readout sequencer
package sarrd_pkg;
    typedef enum logic [2:0] {
        SARRD_DEV_IDLE = 3'b000,
        SARRD_DEV_ACQ = 3'b001,
        SARRD_DEV_CONV = 3'b010,
        SARRD_DEV_DONE = 3'b011,
        SARRD_DEV_READ = 3'b100
    } sarrd_dev_state_t;
    typedef enum logic [2:0] {
        SARRD_HOST_IDLE = 3'b000,
        SARRD_HOST_WAKE = 3'b001,
        SARRD_HOST_START = 3'b010,
        SARRD_HOST_WAIT = 3'b011,
        SARRD_HOST_READ = 3'b100,
        SARRD_HOST_HIGH = 3'b101,
        SARRD_HOST_PUSH = 3'b110
    } sarrd_host_state_t;
endpackage

// *** rtl/sarrd_if.sv ***
// parallel pin bundle between converter sequencer and host
interface sarrd_if #(parameter int WIDTH = 16);
    logic convert_n;
    logic read_select;
    logic upper_byte_select;
    logic done_n;
    logic [WIDTH-1:0] result_bus_o;
    logic result_bus_oe;
    modport dev (
        input convert_n, read_select, upper_byte_select,
        output done_n, result_bus_o, result_bus_oe
    );
    modport host (
        output convert_n, read_select, upper_byte_select,
        input done_n, result_bus_o, result_bus_oe
    );
endinterface

// *** rtl/sarrd_device.sv ***
// converter end: strobe sequencing, conversion timing, three-state result
// Behaviour
// - first strobe, select low: wake, acquire
// - second strobe converts; select picks power-down
// - conversion done within 4.7 us
// - host runs no dummy cycle after shutdown
// - shutdown: reference off after conversion
// - strobe with select low wakes reference
// - host waits 10 ms after wake
// - done flag falls when result ready
// - result bus high-z during acquire/convert
// - third strobe, select high: drive result
// - strobe high returns bus high-z
// - back to done state after read until next strobe
// - full-width or byte-wide result bus
// - upper byte select picks result byte
// - reset with strobe high; acquire next
// - result is straight unsigned binary
`include "sarrd_params.svh"
module sarrd_device #(
    parameter int WIDTH = 16,
    parameter int CONV_CYCLES = `SARRD_CONV_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // link to host
    sarrd_if.dev link,
    // analog core side
    input wire logic [`SARRD_RESULT_BITS-1:0] sample_code_in,
    output logic reference_on_out,
    output logic sampling_out
);
    import sarrd_pkg::*;
    localparam int CW = $clog2(CONV_CYCLES + 1);
    sarrd_dev_state_t state_reg, state_next;
    logic strobe_d_reg, strobe_d_next;
    logic shutdown_reg, shutdown_next;
    logic ref_reg, ref_next;
    logic done_n_reg, done_n_next;
    logic oe_reg, oe_next;
    logic [WIDTH-1:0] bus_reg, bus_next;
    logic [`SARRD_RESULT_BITS-1:0] result_reg, result_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic fall;

    function automatic logic [WIDTH-1:0] pick(
        input logic [`SARRD_RESULT_BITS-1:0] r, input logic upper);
        if (WIDTH >= `SARRD_RESULT_BITS)
            pick = WIDTH'(r);
        else
            pick = upper ? WIDTH'(r[`SARRD_RESULT_BITS-1 -: 8])
                         : WIDTH'(r[7:0]);
    endfunction

    assign fall = strobe_d_reg & ~link.convert_n;

    always_comb begin
        state_next = state_reg;
        strobe_d_next = link.convert_n;
        shutdown_next = shutdown_reg;
        ref_next = ref_reg;
        done_n_next = done_n_reg;
        oe_next = oe_reg;
        bus_next = bus_reg;
        result_next = result_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            SARRD_DEV_IDLE, SARRD_DEV_DONE: begin
                if (fall && !link.read_select) begin
                    state_next = SARRD_DEV_ACQ;
                    ref_next = 1'b1;
                    done_n_next = 1'b1;
                end else if (fall && state_reg == SARRD_DEV_DONE) begin
                    state_next = SARRD_DEV_READ;
                end
            end
            SARRD_DEV_ACQ: begin
                oe_next = 1'b0;
                if (fall) begin
                    state_next = SARRD_DEV_CONV;
                    shutdown_next = link.read_select;
                    result_next = sample_code_in;
                    cnt_next = '0;
                end
            end
            SARRD_DEV_CONV: begin
                oe_next = 1'b0;
                cnt_next = cnt_reg + CW'(1);
                if (cnt_reg == CW'(CONV_CYCLES - 2)) begin
                    state_next = SARRD_DEV_DONE;
                    done_n_next = 1'b0;
                    if (shutdown_reg)
                        ref_next = 1'b0;
                end
            end
            SARRD_DEV_READ: begin
                oe_next = 1'b1;
                bus_next = pick(result_reg, link.upper_byte_select);
                if (link.convert_n) begin
                    oe_next = 1'b0;
                    state_next = SARRD_DEV_DONE;
                end
            end
            default: state_next = SARRD_DEV_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= SARRD_DEV_IDLE;
            strobe_d_reg <= 1'b1;
            shutdown_reg <= 1'b0;
            ref_reg <= 1'b0;
            done_n_reg <= 1'b1;
            oe_reg <= 1'b0;
            bus_reg <= '0;
            result_reg <= '0;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            strobe_d_reg <= strobe_d_next;
            shutdown_reg <= shutdown_next;
            ref_reg <= ref_next;
            done_n_reg <= done_n_next;
            oe_reg <= oe_next;
            bus_reg <= bus_next;
            result_reg <= result_next;
            cnt_reg <= cnt_next;
        end
    end

    assign link.done_n = done_n_reg;
    assign link.result_bus_o = bus_reg;
    assign link.result_bus_oe = oe_reg;
    assign reference_on_out = ref_reg;

    logic samp_reg;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in)
            samp_reg <= 1'b0;
        else
            samp_reg <= (state_next == SARRD_DEV_ACQ);
    end
    assign sampling_out = samp_reg;
endmodule

// *** rtl/sarrd_host.sv ***
// host end: drives strobe sequence, reads result into a two-entry buffer
`include "sarrd_params.svh"
module sarrd_host #(
    parameter int WIDTH = 16,
    parameter int WAKE_CYCLES = `SARRD_WAKE_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // link to converter
    sarrd_if.host link,
    // user request
    input wire logic start_in,
    input wire logic shutdown_in,
    input wire logic from_shutdown_in,
    output logic busy_out,
    // result stream
    output logic [`SARRD_RESULT_BITS-1:0] data_out,
    output logic valid_out,
    input wire logic ready_in
);
    import sarrd_pkg::*;
    localparam int WW = $clog2(WAKE_CYCLES + 1);
    localparam bit BYTE = (WIDTH < `SARRD_RESULT_BITS);
    sarrd_host_state_t state_reg, state_next;
    logic cs_reg, cs_next, rc_reg, rc_next, hb_reg, hb_next;
    logic sd_reg, sd_next, ph_reg, ph_next;
    logic [WW-1:0] wait_reg, wait_next;
    logic [`SARRD_RESULT_BITS-1:0] word_reg, word_next;
    logic [`SARRD_RESULT_BITS-1:0] buf_reg [2], buf_next [2];
    logic [1:0] cnt_reg, cnt_next;
    logic rd_reg, rd_next;
    logic valid_reg;
    logic push, pop;

    assign pop = valid_out && ready_in;
    assign push = state_reg == SARRD_HOST_PUSH && cnt_reg != 2'd2;

    always_comb begin
        state_next = state_reg;
        cs_next = cs_reg;
        rc_next = rc_reg;
        hb_next = hb_reg;
        sd_next = sd_reg;
        ph_next = ph_reg;
        wait_next = wait_reg;
        word_next = word_reg;
        unique case (state_reg)
            SARRD_HOST_IDLE: begin
                if (start_in) begin
                    cs_next = 1'b0;
                    rc_next = 1'b0;
                    sd_next = shutdown_in;
                    wait_next = from_shutdown_in ? WW'(WAKE_CYCLES) : WW'(1);
                    state_next = SARRD_HOST_WAKE;
                end
            end
            SARRD_HOST_WAKE: begin
                cs_next = 1'b1;
                wait_next = wait_reg - WW'(1);
                if (wait_reg <= WW'(1)) begin
                    state_next = SARRD_HOST_START;
                end
            end
            SARRD_HOST_START: begin
                cs_next = 1'b0;
                rc_next = sd_reg;
                state_next = SARRD_HOST_WAIT;
            end
            SARRD_HOST_WAIT: begin
                cs_next = 1'b1;
                if (!link.done_n && cs_reg) begin
                    cs_next = 1'b0;
                    rc_next = 1'b1;
                    hb_next = 1'b0;
                    ph_next = 1'b0;
                    state_next = SARRD_HOST_READ;
                end
            end
            SARRD_HOST_READ: begin
                if (link.result_bus_oe) begin
                    if (!BYTE) begin
                        word_next = `SARRD_RESULT_BITS'(link.result_bus_o);
                        state_next = SARRD_HOST_HIGH;
                    end else if (!ph_reg && !hb_reg) begin
                        word_next[7:0] = link.result_bus_o[7:0];
                        hb_next = 1'b1;
                        ph_next = 1'b1;
                    end else if (ph_reg && hb_reg && rd_reg) begin
                        word_next[15:8] = link.result_bus_o[7:0];
                        state_next = SARRD_HOST_HIGH;
                    end
                end
            end
            SARRD_HOST_HIGH: begin
                cs_next = 1'b1;
                rc_next = 1'b0;
                hb_next = 1'b0;
                state_next = SARRD_HOST_PUSH;
            end
            SARRD_HOST_PUSH: begin
                if (cnt_reg != 2'd2)
                    state_next = SARRD_HOST_IDLE;
            end
            default: state_next = SARRD_HOST_IDLE;
        endcase
    end

    // byte phase waits one cycle for the new byte to settle on the bus
    assign rd_next = state_reg == SARRD_HOST_READ && hb_reg;

    always_comb begin
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        if (pop) begin
            buf_next[0] = buf_reg[1];
            cnt_next = cnt_next - 2'd1;
        end
        if (push) begin
            buf_next[cnt_next[0]] = word_reg;
            cnt_next = cnt_next + 2'd1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= SARRD_HOST_IDLE;
            cs_reg <= 1'b1;
            rc_reg <= 1'b0;
            hb_reg <= 1'b0;
            sd_reg <= 1'b0;
            ph_reg <= 1'b0;
            wait_reg <= '0;
            word_reg <= '0;
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            cnt_reg <= '0;
            rd_reg <= 1'b0;
            busy_out <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cs_reg <= cs_next;
            rc_reg <= rc_next;
            hb_reg <= hb_next;
            sd_reg <= sd_next;
            ph_reg <= ph_next;
            wait_reg <= wait_next;
            word_reg <= word_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
            busy_out <= state_next != SARRD_HOST_IDLE;
            valid_reg <= cnt_next != 2'd0;
        end
    end

    assign link.convert_n = cs_reg;
    assign link.read_select = rc_reg;
    assign link.upper_byte_select = hb_reg;
    assign data_out = buf_reg[0];
    assign valid_out = valid_reg;
endmodule

// *** bench/sarrd_checker.sv ***
// concurrent checks on the pin bundle between converter and host
module sarrd_checker #(
    parameter int WIDTH = 16,
    parameter int CONV_CYCLES = 470
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // pin bundle
    input wire logic convert_n,
    input wire logic read_select,
    input wire logic upper_byte_select,
    input wire logic done_n,
    input wire logic [WIDTH-1:0] result_bus_o,
    input wire logic result_bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] since_fall_reg;
    logic [15:0] since_fall_next;
    logic strobe_reg;
    // cycles since the last strobe fall
    always_comb begin
        since_fall_next = since_fall_reg + 16'h0001;
        if (strobe_reg && !convert_n) begin
            since_fall_next = 16'h0000;
        end
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            since_fall_reg <= 16'h0000;
            strobe_reg <= 1'b1;
        end else begin
            since_fall_reg <= since_fall_next;
            strobe_reg <= convert_n;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence read_fall;
        $fell(convert_n) && read_select && !done_n;
    endsequence
    sequence conv_end;
        $fell(done_n);
    endsequence
    read_drive_a: assert property (read_fall |-> ##[1:3] result_bus_oe)
        else $error("result not driven after read strobe");
    conv_time_a: assert property (conv_end |->
        since_fall_reg >= CONV_CYCLES - 2 && since_fall_reg <= CONV_CYCLES + 2)
        else $error("conversion time off");
    bus_hiz_a: assert property (convert_n [*3] |-> !result_bus_oe)
        else $error("bus driven with strobe high");
    oe_done_a: assert property (result_bus_oe |-> !done_n)
        else $error("bus driven before conversion done");
    oe_strobe_a: assert property ($rose(result_bus_oe) |->
        !convert_n && read_select)
        else $error("bus driven without read strobe");
    bus_stable_a: assert property (result_bus_oe && $past(result_bus_oe) |->
        $stable(result_bus_o))
        else $error("result changed during read");
    done_hold_a: assert property (!done_n && convert_n && $past(convert_n)
        |=> !done_n)
        else $error("done flag rose without strobe");
    done_rise_a: assert property ($rose(done_n) |->
        !$past(convert_n) || !$past(convert_n, 2))
        else $error("done flag rose outside acquisition");
endmodule

// *** bench/tb_sar_adc_parallel_readout_sequencer.sv ***
// self-checking bench for both ends of the readout sequencer
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    bad_count++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end end
module tb_sar_adc_parallel_readout_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE = 20;
    localparam int NARROW = 8;
    localparam int LIMIT = 20000;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic shutdown_in = 1'b0;
    logic from_shutdown_in = 1'b0;
    logic ready_in = 1'b0;
    logic [15:0] code = 16'h0000;
    logic [15:0] data_w, data_n;
    logic valid_w, valid_n, busy_w, busy_n, ref_w, samp_w;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    sarrd_if link_w();
    sarrd_if #(.WIDTH(NARROW)) link_n();
    sarrd_device sarrd_device_i (
        .clock_in(clock_in), .rst_in(rst_in), .link(link_w.dev),
        .sample_code_in(code), .reference_on_out(ref_w),
        .sampling_out(samp_w));
    sarrd_host #(.WAKE_CYCLES(WAKE)) sarrd_host_i (
        .clock_in(clock_in), .rst_in(rst_in), .link(link_w.host),
        .start_in(start_in), .shutdown_in(shutdown_in),
        .from_shutdown_in(from_shutdown_in), .busy_out(busy_w),
        .data_out(data_w), .valid_out(valid_w), .ready_in(ready_in));
    sarrd_device #(.WIDTH(NARROW)) sarrd_device_byte_i (
        .clock_in(clock_in), .rst_in(rst_in), .link(link_n.dev),
        .sample_code_in(code), .reference_on_out(), .sampling_out());
    sarrd_host #(.WIDTH(NARROW), .WAKE_CYCLES(WAKE)) sarrd_host_byte_i (
        .clock_in(clock_in), .rst_in(rst_in), .link(link_n.host),
        .start_in(start_in), .shutdown_in(shutdown_in),
        .from_shutdown_in(from_shutdown_in), .busy_out(busy_n),
        .data_out(data_n), .valid_out(valid_n), .ready_in(ready_in));
    sarrd_checker sarrd_checker_i (
        .clock_in(clock_in), .rst_in(rst_in), .convert_n(link_w.convert_n),
        .read_select(link_w.read_select),
        .upper_byte_select(link_w.upper_byte_select),
        .done_n(link_w.done_n), .result_bus_o(link_w.result_bus_o),
        .result_bus_oe(link_w.result_bus_oe));
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_v(ref logic s, input logic v, input int lim,
            output bit ok);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge clock_in);
            n++;
        end
        ok = (s === v);
    endtask
    task automatic start(input logic sd, input logic fs,
            input logic [15:0] c);
        bit ok;
        @(posedge clock_in);
        code <= c;
        shutdown_in <= sd;
        from_shutdown_in <= fs;
        start_in <= 1'b1;
        @(posedge clock_in);
        start_in <= 1'b0;
        wait_v(samp_w, 1'b1, 100, ok);
        `CHK("acquire", 1'b1, ok)
        `CHK("ref_on", 1'b1, ref_w)
    endtask
    task automatic idle(input int lim, output bit ok);
        bit a, b;
        wait_v(busy_w, 1'b0, lim, a);
        wait_v(busy_n, 1'b0, lim, b);
        ok = a & b;
    endtask
    task automatic take(input logic [15:0] c);
        bit a, b;
        // look away from the edge that pops the previous word
        @(negedge clock_in);
        wait_v(valid_w, 1'b1, 2000, a);
        wait_v(valid_n, 1'b1, 2000, b);
        `CHK("valid", 1'b1, a & b)
        `CHK("word", c, data_w)
        `CHK("bytes", c, data_n)
        @(posedge clock_in);
        ready_in <= 1'b1;
        @(posedge clock_in);
        ready_in <= 1'b0;
    endtask
    // standby, shutdown, then wake from shutdown
    task automatic test_modes();
        logic [15:0] codes [3] = '{16'h0000, 16'hFFFF, 16'hA5C3};
        bit ok;
        for (int i = 0; i < 3; i++) begin
            start(i == 1, i == 2, codes[i]);
            take(codes[i]);
            idle(2000, ok);
            `CHK("ref_after", i != 1, ref_w)
        end
    endtask
    // receiver stalls: two words buffered, third cycle held back
    task automatic test_stall();
        bit ok;
        for (int i = 0; i < 3; i++) begin
            start(1'b0, 1'b0, 16'h1230 + 16'(i));
            idle(1500, ok);
            `CHK("idle", i < 2, ok)
        end
        for (int i = 0; i < 3; i++) begin
            take(16'h1230 + 16'(i));
        end
    endtask
    // reset with strobe high, then a cycle without dummy conversion
    task automatic test_reset();
        bit ok;
        start(1'b0, 1'b0, 16'h7777);
        wait_v(valid_w, 1'b1, 2000, ok);
        `CHK("pending", 1'b1, ok)
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        `CHK("valid_rst", 1'b0, valid_w)
        `CHK("done_rst", 1'b1, link_w.done_n)
        start(1'b0, 1'b0, 16'h8001);
        take(16'h8001);
    endtask
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        test_modes();
        test_stall();
        test_reset();
        close_out();
    end
endmodule
